/* File: design/cocr_consts.svh */
// constants of the clock output control register bank
`ifndef COCR_CONSTS_SVH
`define COCR_CONSTS_SVH

// bus addresses, full byte including the direction bit
`define COCR_WR_ADDR 8'hd2
`define COCR_RD_ADDR 8'hd3

// byte indexes
`define COCR_IDX_DIFF  8'h00
`define COCR_IDX_CPU   8'h01
`define COCR_IDX_SE    8'h02
`define COCR_IDX_SWING 8'h03
`define COCR_IDX_RSVA  8'h04
`define COCR_IDX_RSVB  8'h05
`define COCR_IDX_TEST  8'h06
`define COCR_IDX_REV   8'h07
`define COCR_IDX_BCNT  8'h08
`define COCR_IDX_DEV   8'h09

// field positions
`define COCR_CPU_REF_BIT  7
`define COCR_CPU_LSB      1
`define COCR_SE_PCI_LSB   1
`define COCR_TEST_TYPE    7
`define COCR_TEST_ENTRY   6

// reset values, and the byte sent once the read count runs out
`define COCR_RST_DIFF  8'hff
`define COCR_RST_CPU   4'hf
`define COCR_RST_REF   1'b1
`define COCR_RST_PCI   5'h1f
`define COCR_RST_48M   1'b1
`define COCR_RST_SWING 8'h55
`define COCR_RST_BCNT  8'h01
`define COCR_RST_RSVA  8'h03
`define COCR_RST_RSVB  8'h07
`define COCR_RST_TLOW  6'h12
`define COCR_IDLE_BYTE 8'hff

`endif

/* File: design/cocr_pkg.sv */
// types of the clock output control register bank
package cocr_pkg;
  typedef enum logic [2:0] {
    COCR_ST_IDLE,
    COCR_ST_RECV,
    COCR_ST_ACK,
    COCR_ST_SEND,
    COCR_ST_HACK,
    COCR_ST_HNEXT
  } cocr_st_t;

  typedef enum logic [2:0] {
    COCR_PH_ADDR,
    COCR_PH_INDEX,
    COCR_PH_COUNT,
    COCR_PH_DATA,
    COCR_PH_RCOUNT,
    COCR_PH_RDATA
  } cocr_ph_t;
endpackage

/* File: design/cocr_sync.sv */
// two flip-flop synchroniser for one pin
module cocr_sync (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  // pin and synchronised level
  input  wire logic pin_i,
  output logic      sync_o
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb begin
    meta_d = pin_i;
    sync_d = meta_q;
  end

  // released to 1, the idle level of the bus lines
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;
endmodule

/* File: design/cocr_top.sv */
// clock output control register bank with its serial bus slave
`include "cocr_consts.svh"

module cocr_top
  import cocr_pkg::*;
#(
  parameter logic [3:0] REV_CODE = 4'h3,  // arbitrary value
  parameter logic [3:0] VEND_CODE = 4'h5, // arbitrary value
  parameter logic [7:0] DEV_CODE = 8'h5a  // arbitrary value
) (
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  // serial bus pins
  input  wire logic       smb_clk_i,
  input  wire logic       smb_dat_i,
  output logic            smb_dat_o,
  output logic            smb_dat_oe_n_o,
  // test strap pin
  input  wire logic       test_strap_pin_i,
  // output controls
  output logic [7:0]      diff_en_o,
  output logic            ref_14mhz_en_o,
  output logic [3:0]      cpu_en_o,
  output logic [4:0]      pci_en_o,
  output logic            clk_48mhz_en_o,
  output logic [7:0]      swing_sel_o,
  output logic            test_active_o,
  output logic            test_refdiv_o,
  output logic            test_hiz_o
);

  ////////////////////////////////////////////////////////////////////////////
  logic scl_s;
  logic sda_s;
  logic strap_s;
  logic scl_p_q;
  logic sda_p_q;

  cocr_sync u_sync_scl (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .pin_i(smb_clk_i), .sync_o(scl_s));
  cocr_sync u_sync_sda (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .pin_i(smb_dat_i), .sync_o(sda_s));
  // strap chain runs through reset so the pin level, not the reset value, is caught at release
  cocr_sync u_sync_strap (.clock_i(clock_i), .sys_rst_i(1'b0), .pin_i(test_strap_pin_i), .sync_o(strap_s));

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  assign scl_rise  = scl_s & ~scl_p_q;
  assign scl_fall  = ~scl_s & scl_p_q;
  assign bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign bus_stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;

  ////////////////////////////////////////////////////////////////////////////
  cocr_st_t   st_q,   st_d;
  cocr_ph_t   ph_q,   ph_d;
  logic [3:0] bit_q,  bit_d;
  logic [7:0] sh_q,   sh_d;
  logic [7:0] ptr_q,  ptr_d;
  logic [7:0] wcnt_q, wcnt_d;
  logic [7:0] rcnt_q, rcnt_d;
  logic       drv_q,  drv_d;
  logic       wr_en;
  logic       load;
  logic [7:0] nb;

  logic [7:0] diff_q,  diff_d;
  logic       ref_q,   ref_d;
  logic [3:0] cpu_q,   cpu_d;
  logic [4:0] pci_q,   pci_d;
  logic       en48_q,  en48_d;
  logic [7:0] swing_q, swing_d;
  logic       entry_q, entry_d;
  logic       type_q,  type_d;
  logic [7:0] bcnt_q,  bcnt_d;
  logic       tact_q,  tact_d;
  logic       strap_q, strap_d;
  logic       sdone_q, sdone_d;

  // read view; reserved and identity fields are constants, so writes never reach them
  function automatic logic [7:0] rd_byte(input logic [7:0] idx);
    logic [7:0] r;
    r = 8'h00;
    unique case (idx)
      `COCR_IDX_DIFF:  r = diff_q;
      `COCR_IDX_CPU:   r = {ref_q, 2'b00, cpu_q, 1'b0};
      `COCR_IDX_SE:    r = {2'b00, pci_q, en48_q};
      `COCR_IDX_SWING: r = swing_q;
      `COCR_IDX_RSVA:  r = `COCR_RST_RSVA;
      `COCR_IDX_RSVB:  r = `COCR_RST_RSVB;
      `COCR_IDX_TEST:  r = {type_q, entry_q, `COCR_RST_TLOW};
      `COCR_IDX_REV:   r = {REV_CODE, VEND_CODE};
      `COCR_IDX_BCNT:  r = bcnt_q;
      `COCR_IDX_DEV:   r = DEV_CODE;
      default:         r = 8'h00;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // link engine
  always_comb begin
    st_d   = st_q;
    ph_d   = ph_q;
    bit_d  = bit_q;
    sh_d   = sh_q;
    ptr_d  = ptr_q;
    wcnt_d = wcnt_q;
    rcnt_d = rcnt_q;
    drv_d  = drv_q;
    wr_en  = 1'b0;
    // count byte first, then data until the count runs out
    if (ph_q == COCR_PH_RCOUNT) begin
      nb = bcnt_q;
    end else if (rcnt_q != 8'h00) begin
      nb = rd_byte(ptr_q);
    end else begin
      nb = `COCR_IDLE_BYTE;
    end
    load = scl_fall & (((st_q == COCR_ST_ACK) & (ph_q == COCR_PH_RCOUNT)) | (st_q == COCR_ST_HNEXT));
    if (bus_start) begin
      st_d  = COCR_ST_RECV;
      ph_d  = COCR_PH_ADDR;
      bit_d = 4'h0;
      drv_d = 1'b0;
    end else if (bus_stop) begin
      st_d  = COCR_ST_IDLE;
      drv_d = 1'b0;
    end else if (load) begin
      st_d  = COCR_ST_SEND;
      drv_d = ~nb[7];
      sh_d  = {nb[6:0], 1'b0};
      bit_d = 4'h1;
      if (ph_q == COCR_PH_RCOUNT) begin
        ph_d   = COCR_PH_RDATA;
        rcnt_d = bcnt_q;
      end else if (rcnt_q != 8'h00) begin
        ptr_d  = ptr_q + 8'h01;
        rcnt_d = rcnt_q - 8'h01;
      end
    end else begin
      unique case (st_q)
        COCR_ST_IDLE: begin
        end
        COCR_ST_RECV: begin
          if (scl_rise) begin
            sh_d  = {sh_q[6:0], sda_s};
            bit_d = bit_q + 4'h1;
          end else if (scl_fall && bit_q == 4'h8) begin
            st_d  = COCR_ST_ACK;
            drv_d = 1'b1;
            bit_d = 4'h0;
            unique case (ph_q)
              COCR_PH_ADDR: begin
                if (sh_q == `COCR_WR_ADDR) begin
                  ph_d = COCR_PH_INDEX;
                end else if (sh_q == `COCR_RD_ADDR) begin
                  ph_d = COCR_PH_RCOUNT;
                end else begin
                  st_d  = COCR_ST_IDLE;
                  drv_d = 1'b0;
                end
              end
              COCR_PH_INDEX: begin
                ptr_d = sh_q;
                ph_d  = COCR_PH_COUNT;
              end
              COCR_PH_COUNT: begin
                wcnt_d = sh_q;
                ph_d   = COCR_PH_DATA;
              end
              COCR_PH_DATA: begin
                if (wcnt_q != 8'h00) begin
                  wr_en  = 1'b1;
                  ptr_d  = ptr_q + 8'h01;
                  wcnt_d = wcnt_q - 8'h01;
                end else begin
                  // bytes beyond the announced count are refused
                  st_d  = COCR_ST_IDLE;
                  drv_d = 1'b0;
                end
              end
              default: begin
                st_d  = COCR_ST_IDLE;
                drv_d = 1'b0;
              end
            endcase
          end
        end
        COCR_ST_ACK: begin
          if (scl_fall) begin
            st_d  = COCR_ST_RECV;
            drv_d = 1'b0;
          end
        end
        COCR_ST_SEND: begin
          if (scl_fall) begin
            if (bit_q == 4'h8) begin
              st_d  = COCR_ST_HACK;
              drv_d = 1'b0;
            end else begin
              drv_d = ~sh_q[7];
              sh_d  = {sh_q[6:0], 1'b0};
              bit_d = bit_q + 4'h1;
            end
          end
        end
        COCR_ST_HACK: begin
          if (scl_rise) begin
            st_d = sda_s ? COCR_ST_IDLE : COCR_ST_HNEXT;
          end
        end
        COCR_ST_HNEXT: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      st_q    <= COCR_ST_IDLE;
      ph_q    <= COCR_PH_ADDR;
      bit_q   <= 4'h0;
      sh_q    <= 8'h00;
      ptr_q   <= 8'h00;
      wcnt_q  <= 8'h00;
      rcnt_q  <= 8'h00;
      drv_q   <= 1'b0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      st_q    <= st_d;
      ph_q    <= ph_d;
      bit_q   <= bit_d;
      sh_q    <= sh_d;
      ptr_q   <= ptr_d;
      wcnt_q  <= wcnt_d;
      rcnt_q  <= rcnt_d;
      drv_q   <= drv_d;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register bank and test mode
  always_comb begin
    diff_d  = diff_q;
    ref_d   = ref_q;
    cpu_d   = cpu_q;
    pci_d   = pci_q;
    en48_d  = en48_q;
    swing_d = swing_q;
    entry_d = entry_q;
    type_d  = type_q;
    bcnt_d  = bcnt_q;
    strap_d = strap_q;
    sdone_d = 1'b1;
    // strap caught once, on the first cycle after reset release
    if (!sdone_q) begin
      strap_d = strap_s;
    end
    // only a full reset clears an entered test mode
    tact_d = tact_q | (entry_q & sdone_q & ~strap_q);
    if (wr_en) begin
      unique case (ptr_q)
        `COCR_IDX_DIFF:  diff_d = sh_q;
        `COCR_IDX_CPU: begin
          ref_d = sh_q[`COCR_CPU_REF_BIT];
          cpu_d = sh_q[`COCR_CPU_LSB +: 4];
        end
        `COCR_IDX_SE: begin
          pci_d  = sh_q[`COCR_SE_PCI_LSB +: 5];
          en48_d = sh_q[0];
        end
        `COCR_IDX_SWING: swing_d = sh_q;
        `COCR_IDX_TEST: begin
          entry_d = sh_q[`COCR_TEST_ENTRY];
          type_d  = sh_q[`COCR_TEST_TYPE];
        end
        `COCR_IDX_BCNT:  bcnt_d = sh_q;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      diff_q  <= `COCR_RST_DIFF;
      ref_q   <= `COCR_RST_REF;
      cpu_q   <= `COCR_RST_CPU;
      pci_q   <= `COCR_RST_PCI;
      en48_q  <= `COCR_RST_48M;
      swing_q <= `COCR_RST_SWING;
      entry_q <= 1'b0;
      type_q  <= 1'b0;
      bcnt_q  <= `COCR_RST_BCNT;
      tact_q  <= 1'b0;
      strap_q <= 1'b0;
      sdone_q <= 1'b0;
    end else begin
      diff_q  <= diff_d;
      ref_q   <= ref_d;
      cpu_q   <= cpu_d;
      pci_q   <= pci_d;
      en48_q  <= en48_d;
      swing_q <= swing_d;
      entry_q <= entry_d;
      type_q  <= type_d;
      bcnt_q  <= bcnt_d;
      tact_q  <= tact_d;
      strap_q <= strap_d;
      sdone_q <= sdone_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign smb_dat_o      = 1'b0;
  assign smb_dat_oe_n_o = ~drv_q;
  assign diff_en_o      = diff_q;
  assign ref_14mhz_en_o = ref_q;
  assign cpu_en_o       = cpu_q;
  assign pci_en_o       = pci_q;
  assign clk_48mhz_en_o = en48_q;
  assign swing_sel_o    = swing_q;
  assign test_active_o  = tact_q | (sdone_q & strap_q);
  assign test_refdiv_o  = test_active_o & type_q;
  assign test_hiz_o     = test_active_o & ~type_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  diff_write_a: assert property (wr_en && ptr_q == `COCR_IDX_DIFF |=> diff_en_o == $past(sh_q))
    else $error("differential enables not written");
  cpu_write_a: assert property (wr_en && ptr_q == `COCR_IDX_CPU |=>
    cpu_en_o == $past(sh_q[4:1]) && ref_14mhz_en_o == $past(sh_q[7]))
    else $error("cpu or reference enables not written");
  se_write_a: assert property (wr_en && ptr_q == `COCR_IDX_SE |=>
    pci_en_o == $past(sh_q[5:1]) && clk_48mhz_en_o == $past(sh_q[0]))
    else $error("single ended enables not written");
  swing_hold_a: assert property (!(wr_en && ptr_q == `COCR_IDX_SWING) |=> $stable(swing_sel_o))
    else $error("swing changed without a write");
  entry_take_a: assert property (entry_q && sdone_q && !strap_q |=> test_active_o)
    else $error("software test entry ignored");
  type_sel_a: assert property (test_active_o |-> test_refdiv_o != test_hiz_o)
    else $error("test type outputs inconsistent");
  id_send_a: assert property (load && ph_q == COCR_PH_RDATA && rcnt_q != 8'h00 && ptr_q == `COCR_IDX_REV
    |=> {~drv_q, sh_q[7:1]} == {REV_CODE, VEND_CODE})
    else $error("revision byte wrong");
  dev_send_a: assert property (load && ph_q == COCR_PH_RDATA && rcnt_q != 8'h00 && ptr_q == `COCR_IDX_DEV
    |=> {~drv_q, sh_q[7:1]} == DEV_CODE)
    else $error("device code wrong");
  count_first_a: assert property (load && ph_q == COCR_PH_RCOUNT
    |=> rcnt_q == $past(bcnt_q) && ph_q == COCR_PH_RDATA)
    else $error("count byte not sent first");
  count_end_a: assert property (load && ph_q == COCR_PH_RDATA && rcnt_q == 8'h00 |=> !drv_q)
    else $error("bytes sent beyond count");
  ack_drive_a: assert property (st_q == COCR_ST_ACK |-> !smb_dat_oe_n_o)
    else $error("acknowledge not driven");
  test_persist_a: assert property (tact_q |=> tact_q [*3])
    else $error("test mode dropped");
  rsvd_read_a: assert property ((rd_byte(`COCR_IDX_CPU) & 8'h61) == 8'h00)
    else $error("reserved bits changed");

  write_cov: cover property (wr_en ##1 wr_en);
  read_cov: cover property (load && ph_q == COCR_PH_RCOUNT);
  test_cov: cover property ($rose(tact_q));
  nack_cov: cover property (st_q == COCR_ST_HACK && scl_rise && sda_s);
endmodule

/* File: sim/cocr_host_model.sv */
// serial bus host model driving the clock and data pins of the register bank
module cocr_host_model (
  // clock
  input  wire logic clock_i,
  // bus pins, sda_o high means released
  output logic      scl_o,
  output logic      sda_o,
  input  wire logic sda_i
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic w(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  // low and high phases of 8 cycles stay well above the 4 cycle minimum of the synchronisers
  task automatic bit_cycle(input logic b, output logic s);
    w(4);
    sda_o = b;
    w(4);
    scl_o = 1'b1;
    w(4);
    s = sda_i;
    w(4);
    scl_o = 1'b0;
  endtask

  // same shape serves a first start and a repeated start
  task automatic start_c;
    w(4);
    sda_o = 1'b1;
    w(6);
    scl_o = 1'b1;
    w(8);
    sda_o = 1'b0;
    w(8);
    scl_o = 1'b0;
  endtask

  task automatic stop_c;
    w(4);
    sda_o = 1'b0;
    w(4);
    scl_o = 1'b1;
    w(8);
    sda_o = 1'b1;
    w(8);
  endtask

  // msb first, ninth bit released so the device can acknowledge
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(d[i], s);
    end
    bit_cycle(1'b1, s);
    ack = ~s;
  endtask

  // host acknowledges each byte and ends with a not-acknowledge
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, s);
      d[i] = s;
    end
    bit_cycle(last, s);
  endtask
endmodule

/* File: sim/tb_clock_output_control_regs.sv */
// self-checking bench of the clock output control register bank
`include "cocr_consts.svh"
module tb_clock_output_control_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import cocr_pkg::*;

  localparam logic [3:0] REV  = 4'h3; // arbitrary value
  localparam logic [3:0] VEND = 4'h5; // arbitrary value
  localparam logic [7:0] DEV  = 8'h5a; // arbitrary value

  logic       clock_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic       strap = 1'b0;
  logic       scl, host_sda, sda_w, dat_o, oe_n;
  logic [7:0] diff, swing;
  logic [3:0] cpu;
  logic [4:0] pci;
  logic       ref14, m48, t_act, t_ref, t_hiz;
  logic [7:0] wb [16];
  logic [7:0] eb [16];
  int         mismatches = 0;
  int         samples_checked = 0;

  always #12.5 clock_i = ~clock_i;

  // open-drain data line with pull-up
  assign sda_w = host_sda & (oe_n | dat_o);

  cocr_host_model host_u (.clock_i(clock_i), .scl_o(scl), .sda_o(host_sda), .sda_i(sda_w));

  cocr_top #(.REV_CODE(REV), .VEND_CODE(VEND), .DEV_CODE(DEV)) dut_u (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .smb_clk_i(scl), .smb_dat_i(sda_w),
    .smb_dat_o(dat_o), .smb_dat_oe_n_o(oe_n), .test_strap_pin_i(strap),
    .diff_en_o(diff), .ref_14mhz_en_o(ref14), .cpu_en_o(cpu), .pci_en_o(pci),
    .clk_48mhz_en_o(m48), .swing_sel_o(swing), .test_active_o(t_act),
    .test_refdiv_o(t_ref), .test_hiz_o(t_hiz));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // strap must stand two edges before release for the synchroniser
  task automatic do_reset(input logic s);
    @(negedge clock_i);
    strap = s;
    sys_rst_i = 1'b1;
    repeat (4) @(negedge clock_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge clock_i);
  endtask

  task automatic chk_out(input logic [26:0] exp);
    check({diff, ref14, cpu, pci, m48, swing}, exp);
  endtask

  // bytes beyond the count n are expected to be refused
  task automatic blk_wr(input logic [7:0] idx, input int n, input int nsend);
    logic ack;
    host_u.start_c();
    host_u.wbyte(`COCR_WR_ADDR, ack);
    check(ack, 1'b1);
    host_u.wbyte(idx, ack);
    check(ack, 1'b1);
    host_u.wbyte(n[7:0], ack);
    check(ack, 1'b1);
    for (int i = 0; i < nsend; i++) begin
      host_u.wbyte(wb[i], ack);
      check(ack, i < n);
    end
    host_u.stop_c();
  endtask

  task automatic blk_rd(input logic [7:0] idx, input logic [7:0] cnt, input int nread);
    logic       ack;
    logic [7:0] d;
    host_u.start_c();
    host_u.wbyte(`COCR_WR_ADDR, ack);
    check(ack, 1'b1);
    host_u.wbyte(idx, ack);
    check(ack, 1'b1);
    host_u.start_c();
    host_u.wbyte(`COCR_RD_ADDR, ack);
    check(ack, 1'b1);
    host_u.rbyte(1'b0, d);
    check(d, cnt);
    for (int i = 0; i < nread; i++) begin
      host_u.rbyte(i == nread - 1, d);
      check(d, eb[i]);
    end
    host_u.stop_c();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clock_i);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    logic ack;
    do_reset(1'b0);
    chk_out({8'hff, 1'b1, 4'hf, 5'h1f, 1'b1, 8'h55});
    check({t_act, t_ref, t_hiz}, 3'b000);
    // writes to reserved and read-only bytes, count set to ten
    wb[0:6] = '{8'hff, 8'hff, 8'h00, 8'hff, 8'h0a, 8'hff, 8'h00};
    blk_wr(8'h04, 6, 7);
    eb[0:10] = '{8'hff, 8'h9e, 8'h3f, 8'h55, 8'h03, 8'h07, 8'h12, {REV, VEND}, 8'h0a, DEV, 8'hff};
    blk_rd(8'h00, 8'h0a, 11);
    // cpu, reference and single ended enables cleared, differential enables a5, reserved bits written high, swing codes all different
    wb[0:3] = '{8'ha5, 8'h61, 8'hc0, 8'he4};
    blk_wr(8'h00, 4, 5);
    chk_out({8'ha5, 1'b0, 4'h0, 5'h00, 1'b0, 8'he4});
    eb[0:3] = '{8'ha5, 8'h00, 8'h00, 8'he4};
    blk_rd(8'h00, 8'h0a, 4);
    // shorter count limits the block read
    wb[0] = 8'h02;
    blk_wr(8'h08, 1, 1);
    eb[0:2] = '{8'h00, 8'he4, 8'hff};
    blk_rd(8'h02, 8'h02, 3);
    // foreign address is not acknowledged
    host_u.start_c();
    host_u.wbyte(8'ha0, ack);
    check(ack, 1'b0);
    host_u.stop_c();
    // software test entry, type select, then entry bit cleared
    wb[0] = 8'h40;
    blk_wr(8'h06, 1, 1);
    check({t_act, t_ref, t_hiz}, 3'b101);
    wb[0] = 8'hc0;
    blk_wr(8'h06, 1, 1);
    check({t_act, t_ref, t_hiz}, 3'b110);
    eb[0] = 8'hd2;
    blk_rd(8'h06, 8'h02, 1);
    wb[0] = 8'h80;
    blk_wr(8'h06, 1, 1);
    check({t_act, t_ref, t_hiz}, 3'b110);
    // strap high at reset forces test mode whatever the entry bit
    do_reset(1'b1);
    check({t_act, t_ref, t_hiz}, 3'b101);
    chk_out({8'hff, 1'b1, 4'hf, 5'h1f, 1'b1, 8'h55});
    wb[0] = 8'h80;
    blk_wr(8'h06, 1, 1);
    check({t_act, t_ref, t_hiz}, 3'b110);
    do_reset(1'b0);
    check({t_act, t_ref, t_hiz}, 3'b000);
    tally_and_finish();
  end
endmodule
